// >>> src/lwdc_ctrl.sv
// APB register file and window claim gating for the LPC bridge.
`timescale 1ns/100ps
// Behaviour
// - An I/O disable mask bit of one stops I/O claims for its device.
// - I/O mask bit i belongs to logical device i, listed 0 to 63.
// - Host-domain reset copies the seed, default 002Eh, into 60h.
// - A memory disable mask bit of one stops memory claims.
// - With its mask bit zero a memory window follows its valid flag.
// - Memory mask bits are all read/write; reserved ones do nothing.
// - One LPC memory block maps onto an AHB region with 24-bit base.
// - The AHB base is shifted left by eight, a 256-byte boundary.
// - The inhibit bit refuses host access to the mapped block.
// - The size field gives the low address bits passed; 2^min(size, 12) bytes.
module lwdc_ctrl (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   host_domain_reset_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [63:0]            io_hit,
    input  wire logic [63:0]            io_valid,
    input  wire logic [63:0]            mem_hit,
    input  wire logic [63:0]            mem_valid,
    output logic [63:0]                 io_claim,
    output logic [63:0]                 mem_claim,
    output logic [15:0]                 bridge_io_base,
    input  wire lwdc_pkg::lwdc_mem_req_t sram_req,
    output lwdc_pkg::lwdc_mem_rsp_t     sram_rsp
);
    logic [63:0]              io_mask_r;
    logic [63:0]              mem_mask_r;
    logic [15:0]              seed_r;
    logic [15:0]              bridge_r;
    logic [31:0]              lbase_r;
    lwdc_pkg::lwdc_sram_cfg_t cfg_r;
    logic [31:0]              prdata_r;
    logic                     err_r;
    logic [31:0]              rd_nxt;
    logic                     err_nxt;
    logic                     setup;
    logic                     wr;
    logic [2:0]               hrst_s_r;
    logic                     hrst_act_r;
    logic [63:0]              io_claim_nxt;
    logic [63:0]              mem_claim_nxt;

    ////////////////////////////////////////////////////////////////////
    // Merges write data into a register under the byte strobes.
    function automatic logic [31:0] lwdc_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction : lwdc_merge

    ////////////////////////////////////////////////////////////////////
    // Read data is sampled in the setup cycle so that it leaves a
    // flip-flop; the cost is nothing, since the slave never waits.
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite & ~err_r;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & err_r;
    assign prdata  = prdata_r;

    always_comb begin
        rd_nxt  = lwdc_pkg::ZERO32;
        err_nxt = 1'b0;
        if (paddr == lwdc_pkg::A_IOMSK_LO) begin
            rd_nxt = io_mask_r[31:0];
        end else if (paddr == lwdc_pkg::A_IOMSK_HI) begin
            rd_nxt = io_mask_r[63:32];
        end else if (paddr == lwdc_pkg::A_SEED) begin
            rd_nxt = {16'h0000, seed_r};
        end else if (paddr == lwdc_pkg::A_MEMMSK_LO) begin
            rd_nxt = mem_mask_r[31:0];
        end else if (paddr == lwdc_pkg::A_MEMMSK_HI) begin
            rd_nxt = mem_mask_r[63:32];
        end else if (paddr == lwdc_pkg::A_BRIDGE_IO) begin
            rd_nxt = {16'h0000, bridge_r};
        end else if (paddr == lwdc_pkg::A_SRAM_LBASE) begin
            rd_nxt = lbase_r;
        end else if (paddr == lwdc_pkg::A_SRAM_CFG) begin
            rd_nxt = cfg_r & lwdc_pkg::CFG_WMASK;
        end else begin
            err_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= lwdc_pkg::ZERO32;
            err_r    <= 1'b0;
        end else if (setup) begin
            prdata_r <= rd_nxt;
            err_r    <= err_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Disable masks; both clear on system reset.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            io_mask_r <= lwdc_pkg::MASK_RST;
        end else if (wr && paddr == lwdc_pkg::A_IOMSK_LO) begin
            io_mask_r[31:0] <= lwdc_merge(io_mask_r[31:0], pwdata,
                                          pstrb);
        end else if (wr && paddr == lwdc_pkg::A_IOMSK_HI) begin
            io_mask_r[63:32] <= lwdc_merge(io_mask_r[63:32], pwdata,
                                           pstrb);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_mask_r <= lwdc_pkg::MASK_RST;
        end else if (wr && paddr == lwdc_pkg::A_MEMMSK_LO) begin
            mem_mask_r[31:0] <= lwdc_merge(mem_mask_r[31:0], pwdata,
                                           pstrb);
        end else if (wr && paddr == lwdc_pkg::A_MEMMSK_HI) begin
            mem_mask_r[63:32] <= lwdc_merge(mem_mask_r[63:32], pwdata,
                                            pstrb);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Seed and host memory mapping registers.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seed_r <= lwdc_pkg::SEED_RST;
        end else if (wr && paddr == lwdc_pkg::A_SEED) begin
            seed_r <= 16'(lwdc_merge({16'h0000, seed_r}, pwdata, pstrb));
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= lwdc_pkg::CFG_RST;
        end else if (wr && paddr == lwdc_pkg::A_SRAM_CFG) begin
            cfg_r <= lwdc_merge(cfg_r, pwdata, pstrb)
                     & lwdc_pkg::CFG_WMASK;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lbase_r <= lwdc_pkg::LBASE_RST;
        end else if (wr && paddr == lwdc_pkg::A_SRAM_LBASE) begin
            lbase_r <= lwdc_merge(lbase_r, pwdata, pstrb);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Host-domain reset arrives from a pin: three stages, and a change
    // counts only once the second and third stages agree.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrst_s_r <= 3'b111;
        end else begin
            hrst_s_r <= {hrst_s_r[1:0], host_domain_reset_n};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrst_act_r <= 1'b0;
        end else if (!hrst_s_r[1] && !hrst_s_r[2]) begin
            hrst_act_r <= 1'b1;
        end else if (hrst_s_r[1] && hrst_s_r[2]) begin
            hrst_act_r <= 1'b0;
        end
    end

    // The seed is reloaded on every cycle of host-domain reset, so the
    // value that counts is the one standing when that reset ends.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bridge_r <= lwdc_pkg::BRIDGE_RST;
        end else if (hrst_act_r) begin
            bridge_r <= seed_r;
        end else if (wr && paddr == lwdc_pkg::A_BRIDGE_IO) begin
            bridge_r <= 16'(lwdc_merge({16'h0000, bridge_r}, pwdata,
                                       pstrb));
        end
    end

    assign bridge_io_base = bridge_r;

    ////////////////////////////////////////////////////////////////////
    // Per-device claim gating. Reserved device numbers never claim, so
    // their mask bits store a value but steer nothing.
    for (genvar i = 0; i < lwdc_pkg::NDEV; i++) begin : g_dev
        assign io_claim_nxt[i]  = io_hit[i] & io_valid[i]
                                  & lwdc_pkg::DEV_IMPL[i]
                                  & ~io_mask_r[i];
        assign mem_claim_nxt[i] = mem_hit[i] & mem_valid[i]
                                  & lwdc_pkg::DEV_IMPL[i]
                                  & ~mem_mask_r[i];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            io_claim  <= lwdc_pkg::MASK_RST;
            mem_claim <= lwdc_pkg::MASK_RST;
        end else begin
            io_claim  <= io_claim_nxt;
            mem_claim <= mem_claim_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alignment of the AHB base to the block size is left to firmware;
    // the low bits of a misaligned base are simply replaced by host address bits.
    lwdc_sram_xlate u_xlate (
        .clk      (clk),
        .resetn   (resetn),
        .cfg      (cfg_r),
        .lpc_base (lbase_r),
        .req      (sram_req),
        .rsp      (sram_rsp)
    );

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_mem_wr_lo;
        psel && !penable && pwrite && paddr == lwdc_pkg::A_MEMMSK_LO
            && pstrb == 4'hf ##1 psel && penable;
    endsequence

    sequence s_host_rst;
        !hrst_s_r[1] && !hrst_s_r[2] ##1 hrst_act_r;
    endsequence

    a_io_mask_gate: assert property (
        io_claim == $past(io_hit & io_valid & ~io_mask_r
                          & lwdc_pkg::DEV_IMPL))
        else $error("I/O claim disagrees with mask and valid");
    a_io_bit_map: assert property (
        io_mask_r[5] |=> !io_claim[5])
        else $error("masked device five claimed I/O");
    a_mem_mask_gate: assert property (
        (|(mem_claim & $past(mem_mask_r))) == 1'b0)
        else $error("memory claim for masked device");
    a_mem_valid_only: assert property (
        !mem_mask_r[0] && mem_hit[0] |=> mem_claim[0] == $past(mem_valid[0]))
        else $error("unmasked window ignores valid flag");
    a_mem_mask_rw: assert property (
        s_mem_wr_lo |=> mem_mask_r[31:0] == $past(pwdata))
        else $error("memory mask write not stored");
    a_seed_load: assert property (
        s_host_rst ##0 !wr |=> bridge_r == $past(seed_r))
        else $error("bridge window not seeded on host reset");
    a_sys_reset: assert property (
        $rose(resetn) |-> io_mask_r == lwdc_pkg::MASK_RST
            && mem_mask_r == lwdc_pkg::MASK_RST && cfg_r == '0)
        else $error("masks or mapping not cleared by reset");
    a_cfg_rsvd: assert property (
        cfg_r.rsvd == 3'h0)
        else $error("reserved mapping bits stored");
endmodule : lwdc_ctrl

// >>> src/lwdc_pkg.sv
// Package with register map, field layouts and types for window decode control.
package lwdc_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          NDEV         = 64;
    localparam logic [7:0]  A_IOMSK_LO   = 8'h20;
    localparam logic [7:0]  A_IOMSK_HI   = 8'h24;
    localparam logic [7:0]  A_SEED       = 8'h30;
    localparam logic [7:0]  A_MEMMSK_LO  = 8'h40;
    localparam logic [7:0]  A_MEMMSK_HI  = 8'h44;
    localparam logic [7:0]  A_BRIDGE_IO  = 8'h60;
    localparam logic [7:0]  A_SRAM_LBASE = 8'h68;
    localparam logic [7:0]  A_SRAM_CFG   = 8'hfc;
    localparam logic [63:0] MASK_RST     = 64'h0000_0000_0000_0000;
    localparam logic [15:0] SEED_RST     = 16'h002e;
    localparam logic [15:0] BRIDGE_RST   = 16'h0000;
    localparam logic [31:0] LBASE_RST    = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK    = 32'hffff_ff8f;
    localparam logic [31:0] ZERO32       = 32'h0000_0000;
    localparam logic [31:0] ONES32       = 32'hffff_ffff;
    // Logical devices 32 to 63 are reserved and never decode.
    localparam logic [63:0] DEV_IMPL     = 64'h0000_0000_ffff_ffff;
    localparam logic [3:0]  SIZE_MAX     = 4'hc;
    localparam int          BASE_SHIFT   = 8;

    typedef struct packed {
        logic [23:0] ahb_base;
        logic        inhibit;
        logic [2:0]  rsvd;
        logic [3:0]  size;
    } lwdc_sram_cfg_t;

    localparam lwdc_sram_cfg_t CFG_RST = '0;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } lwdc_mem_req_t;

    typedef struct packed {
        logic        claim;
        logic        refused;
        logic [31:0] ahb_addr;
    } lwdc_mem_rsp_t;
endpackage : lwdc_pkg

// >>> src/lwdc_sram_xlate.sv
// Host memory block claim and LPC to AHB address translation.
`timescale 1ns/100ps
module lwdc_sram_xlate (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire lwdc_pkg::lwdc_sram_cfg_t cfg,
    input  wire logic [31:0]             lpc_base,
    input  wire lwdc_pkg::lwdc_mem_req_t req,
    output lwdc_pkg::lwdc_mem_rsp_t      rsp
);
    logic [3:0]  size_eff;
    logic [31:0] pass_mask;
    logic [31:0] base_ahb;
    logic        in_block;

    ////////////////////////////////////////////////////////////////////
    // Sizes above the largest legal one are clamped, so a bad program
    // still yields a bounded, predictable window.
    assign size_eff  = (cfg.size > lwdc_pkg::SIZE_MAX) ?
                       lwdc_pkg::SIZE_MAX : cfg.size;
    assign pass_mask = ~(lwdc_pkg::ONES32 << size_eff);
    assign base_ahb  = 32'(cfg.ahb_base)
                       << lwdc_pkg::BASE_SHIFT;
    assign in_block  = ((req.addr ^ lpc_base) & ~pass_mask)
                       == lwdc_pkg::ZERO32;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsp <= '0;
        end else begin
            rsp.claim    <= req.valid & in_block
                            & ~cfg.inhibit;
            rsp.refused  <= req.valid & in_block
                            & cfg.inhibit;
            if (req.valid && in_block) begin
                rsp.ahb_addr <= (base_ahb & ~pass_mask)
                                | (req.addr & pass_mask);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_inhibit_refuse: assert property (
        cfg.inhibit |=> !rsp.claim)
        else $error("block claimed while inhibited");
    a_base_upper: assert property (
        rsp.claim |-> rsp.ahb_addr[7:0] == ($past(req.addr[7:0])
            & $past(pass_mask[7:0])))
        else $error("low AHB byte not from host address");
    a_size_pass: assert property (
        req.valid && in_block && cfg.size == 4'h0 |=>
            rsp.ahb_addr == $past(base_ahb))
        else $error("size zero must pass no address bits");
    a_claim_range: assert property (
        req.valid && !in_block |=> !rsp.claim && !rsp.refused)
        else $error("claim outside the mapped block");
endmodule : lwdc_sram_xlate

// >>> verif/lwdc_host_model.sv
// Host side model: window hit flags and host memory requests.
`timescale 1ns/100ps
module lwdc_host_model (
    input  wire logic                    clk,
    output logic [63:0]                  io_hit,
    output logic [63:0]                  io_valid,
    output logic [63:0]                  mem_hit,
    output logic [63:0]                  mem_valid,
    output lwdc_pkg::lwdc_mem_req_t      sram_req,
    input  wire logic [63:0]             io_claim,
    input  wire logic [63:0]             mem_claim,
    input  wire lwdc_pkg::lwdc_mem_rsp_t sram_rsp
);
    initial begin
        io_hit    = '0;
        io_valid  = '0;
        mem_hit   = '0;
        mem_valid = '0;
        sram_req  = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags last one cycle and then drop, so a stale flag never poses as a
    // second lookup; the claims are read one cycle after the flags drop, two after they are driven.
    task automatic probe(input logic [63:0] ih, input logic [63:0] iv,
                         input logic [63:0] mh, input logic [63:0] mv,
                         output logic [63:0] ic, output logic [63:0] mc);
        @(posedge clk);
        io_hit    <= ih;
        io_valid  <= iv;
        mem_hit   <= mh;
        mem_valid <= mv;
        @(posedge clk);
        io_hit    <= '0;
        io_valid  <= '0;
        mem_hit   <= '0;
        mem_valid <= '0;
        @(posedge clk);
        ic = io_claim;
        mc = mem_claim;
    endtask : probe

    // The address is inverted once the request is gone, so a design that
    // latches it late sees a wrong value instead of a lucky match.
    task automatic host_mem(input logic [31:0] a,
                            output lwdc_pkg::lwdc_mem_rsp_t r);
        @(posedge clk);
        sram_req <= {1'b1, a};
        @(posedge clk);
        sram_req <= {1'b0, ~a};
        @(posedge clk);
        r = sram_rsp;
    endtask : host_mem
endmodule : lwdc_host_model

// >>> verif/lwdc_ctrl_bench.sv
// Self-checking bench for the window decode control block.
`timescale 1ns/100ps
module lwdc_ctrl_bench;
    logic                    clk;
    logic                    resetn;
    logic                    host_domain_reset_n;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [7:0]              paddr;
    logic [31:0]             pwdata;
    logic [3:0]              pstrb;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic [63:0]             io_hit;
    logic [63:0]             io_valid;
    logic [63:0]             mem_hit;
    logic [63:0]             mem_valid;
    logic [63:0]             io_claim;
    logic [63:0]             mem_claim;
    logic [15:0]             bridge_io_base;
    lwdc_pkg::lwdc_mem_req_t sram_req;
    lwdc_pkg::lwdc_mem_rsp_t sram_rsp;
    lwdc_pkg::lwdc_mem_rsp_t r;
    int                      bad_count;
    int                      n_tests;
    logic [31:0]             rd;
    logic                    err;
    logic [63:0]             ic;
    logic [63:0]             mc;
    logic [63:0]             mi;
    logic [63:0]             mm;
    logic [63:0]             v;
    logic [31:0]             m;
    logic [31:0]             a;
    logic [63:0]             all1 = {2{lwdc_pkg::ONES32}};
    logic [7:0]              ra [7] = '{8'h20, 8'h24, 8'h40, 8'h44,
                                        8'hfc, 8'h68, 8'h30};

    lwdc_ctrl u_lwdc_ctrl (.clk(clk), .resetn(resetn),
        .host_domain_reset_n(host_domain_reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .io_hit(io_hit), .io_valid(io_valid), .mem_hit(mem_hit),
        .mem_valid(mem_valid), .io_claim(io_claim), .mem_claim(mem_claim),
        .bridge_io_base(bridge_io_base), .sram_req(sram_req),
        .sram_rsp(sram_rsp));

    lwdc_host_model u_lwdc_host_model (.clk(clk), .io_hit(io_hit),
        .io_valid(io_valid), .mem_hit(mem_hit), .mem_valid(mem_valid),
        .sram_req(sram_req), .io_claim(io_claim), .mem_claim(mem_claim),
        .sram_rsp(sram_rsp));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d, 4'hf);
    endtask : wr

    task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, lwdc_pkg::ZERO32, 4'hf);
        chk({31'h0, err, rd}, {32'h0, exp});
    endtask : rdc

    task automatic reset_vals();
        foreach (ra[i]) begin
            rdc(ra[i], i == 6 ? 32'h0000_002e : 32'h0);
        end
        $display("test reset_values done");
    endtask : reset_vals

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        conclude();
    end

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        host_domain_reset_n = 1'b1;
        bad_count = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        reset_vals();
        apb(1'b0, 8'h10, lwdc_pkg::ONES32, 4'hf);
        chk({31'h0, err, rd}, 64'h0000_0001_0000_0000);
        apb(1'b1, 8'h30, 32'h0000_3412, 4'h1);
        rdc(8'h30, 32'h0000_0012);
        $display("test access_kinds done");
        for (int k = 0; k < 2; k++) begin
            mi = k ? 64'h0 : 64'hffff_0000_8000_0025;
            mm = k ? 64'h0 : 64'h0000_ffff_0000_a001;
            wr(8'h20, mi[31:0]);
            wr(8'h24, mi[63:32]);
            wr(8'h40, mm[31:0]);
            wr(8'h44, mm[63:32]);
            rdc(8'h44, mm[63:32]);
            v = k ? 64'hf0f0_f0f0_1234_5678 : all1;
            u_lwdc_host_model.probe(all1, v, all1, v, ic, mc);
            chk(ic, v & ~mi & lwdc_pkg::DEV_IMPL);
            mm = v & ~mm & lwdc_pkg::DEV_IMPL;
            chk(mc, mm);
        end
        $display("test claim_masks done");
        wr(8'h30, 32'h0000_4c21);
        wr(8'h60, 32'h0000_1111);
        rdc(8'h60, 32'h0000_1111);
        host_domain_reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        host_domain_reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        rdc(8'h60, 32'h0000_4c21);
        chk({48'h0, bridge_io_base}, 64'h0000_0000_0000_4c21);
        $display("test host_reset done");
        wr(8'h68, 32'h000f_f000);
        for (int s = 0; s <= 12; s += 4) begin
            m = (32'h1 << s) - 32'h1;
            wr(8'hfc, {24'h8f_1230, 4'h0, s[3:0]});
            a = 32'h000f_f000 | (32'h0000_0ba6 & m);
            u_lwdc_host_model.host_mem(a, r);
            chk({r.claim, r.refused}, 2'b10);
            m = (32'h8f12_3000 & ~m) | (a & m);
            chk(r.ahb_addr, m);
            u_lwdc_host_model.host_mem(a + (32'h1 << s), r);
            chk({r.claim, r.refused}, 2'b00);
        end
        wr(8'hfc, 32'h8f12_30fc);
        rdc(8'hfc, 32'h8f12_308c);
        u_lwdc_host_model.host_mem(32'h000f_f123, r);
        chk({r.claim, r.refused}, 2'b01);
        $display("test host_block done");
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        reset_vals();
        conclude();
    end
endmodule : lwdc_ctrl_bench
